// ---- bbefc_boost_model.sv ----
// Behavioural boost power stage and LED sinks facing the controller.
// Assumes the bench commands every fault except under-voltage while ramping, which the model raises itself; the ramp ends a fixed time after the rail turns on.
`timescale 1ns/1ps
module bbefc_boost_model #(
  parameter int RAMP_CYC = 100050
) (
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       rail_in,
  input  wire logic       inj_uv_in,
  input  wire logic       inj_ov_in,
  input  wire logic       inj_oc_in,
  input  wire logic       inj_short_in,
  input  wire logic [2:0] inj_open_in,
  output logic            uv_out,
  output logic            ov_out,
  output logic            oc_out,
  output logic            short_out,
  output logic            steady_out,
  output logic [2:0]      open_out
);
  logic [17:0] ramp_q;

  // Output voltage builds up only while the rail runs; dropping the rail discharges the count
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ramp_q <= 18'h00000;
    end else if (!rail_in) begin
      ramp_q <= 18'h00000;
    end else if (int'(ramp_q) < RAMP_CYC) begin
      ramp_q <= ramp_q + 18'h00001;
    end
  end

  assign steady_out = rail_in && (int'(ramp_q) >= RAMP_CYC);
  // Output sits below the threshold while it is still ramping
  assign uv_out     = inj_uv_in || (rail_in && !steady_out);
  assign ov_out     = inj_ov_in;
  assign oc_out     = inj_oc_in;
  assign short_out  = inj_short_in;
  assign open_out   = inj_open_in;
endmodule : bbefc_boost_model

// ---- bbefc_ctrl.sv ----
// Backlight boost enable decode, string routing and fault flag merge.
// Assumes classic Wishbone master on core_clk_in; detector inputs are asynchronous.
`timescale 1ns/1ps
`include "bbefc_regs.svh"
module bbefc_ctrl (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  output logic             irq_out,
  // Analog detectors
  input  wire logic        uv_detect_in,
  input  wire logic        ov_detect_in,
  input  wire logic        oc_detect_in,
  input  wire logic        short_detect_in,
  input  wire logic        steady_state_in,
  input  wire logic [2:0]  open_string_in,
  // Boost stage controls
  output logic             backlight_boost_rail_out,
  output logic             regulator_run_out,
  output logic             switch_off_out,
  output logic             uv_comparator_en_out,
  output logic             fixed_reference_out,
  output logic             clamp_22v_out,
  output logic             boost_fault_flag_out,
  // Per-string control: mode, zone (0 = zone_one, 1 = zone_two), sink enable
  output logic [7:0]       string_mode_out,
  output logic [3:0]       string_zone_two_out,
  output logic [3:0]       string_sink_en_out,
  output logic [2:0]       loop_member_out
);
  localparam logic [16:0] SS_CYC = 17'(`BBEFC_SS_CYCLES);

  logic [`BBEFC_CTRL_W-1:0] ctrl_q;
  logic [`BBEFC_EV_W-1:0]   ev_stat_q;
  logic [`BBEFC_EV_W-1:0]   ev_mask_q;
  logic [`BBEFC_EV_W-1:0]   ev_set;
  logic [16:0]              ss_cnt_q;
  logic                     short_q;
  logic                     fault_q;
  logic                     short_off_q;
  logic [7:0]               open_s;
  logic                     uv_s, ov_s, oc_s, sc_s, steady_s;
  logic [2:0]               open_s3;
  logic [2:0]               open_prev_q;
  bbefc_pkg::bbefc_boost_st_t st_q;

  // Detector levels cross into the core domain
  bbefc_sync #(.W(8)) u_sync (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .async_in    ({uv_detect_in, ov_detect_in, oc_detect_in, short_detect_in,
                   steady_state_in, open_string_in}),
    .sync_out    (open_s)
  );
  assign {uv_s, ov_s, oc_s, sc_s, steady_s, open_s3} = open_s;

  // Decoded control bits
  logic [2:0] main_en;
  logic       fourth_en, scene_en, dual_sel, pwm_mode, any_main, boost_req, fourth_bl;
  assign main_en   = ctrl_q[`BBEFC_CTRL_MAIN_MSB:`BBEFC_CTRL_MAIN_LSB];
  assign scene_en  = ctrl_q[`BBEFC_CTRL_SCENE];
  assign fourth_en = ctrl_q[`BBEFC_CTRL_FOURTH] & scene_en;
  assign dual_sel  = ctrl_q[`BBEFC_CTRL_DUAL];
  // Main enables are gated off in PWM mode; software must not combine them
  assign pwm_mode  = ctrl_q[`BBEFC_CTRL_PWM];
  assign any_main  = |main_en & ~pwm_mode;
  assign boost_req = any_main | scene_en;
  assign fourth_bl = fourth_en | (dual_sel & scene_en);

  // Wishbone register writes, byte lane 0 carries every field
  logic wr_stb;
  assign wr_stb = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out & wb_sel_in[0];

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= `BBEFC_CTRL_RST;
    end else if (wr_stb && wb_adr_in == `BBEFC_ADR_CTRL) begin
      ctrl_q <= wb_dat_in[`BBEFC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_mask_q <= `BBEFC_EV_RST;
    end else if (wr_stb && wb_adr_in == `BBEFC_ADR_IRQ_MASK) begin
      ev_mask_q <= wb_dat_in[`BBEFC_EV_W-1:0];
    end
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_stat_q <= `BBEFC_EV_RST;
    end else if (wr_stb && wb_adr_in == `BBEFC_ADR_IRQ_STAT) begin
      ev_stat_q <= (ev_stat_q & ~wb_dat_in[`BBEFC_EV_W-1:0]) | ev_set;
    end else begin
      ev_stat_q <= ev_stat_q | ev_set;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ev_stat_q & ev_mask_q);
    end
  end

  // Single-cycle acknowledge and read data
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      case (wb_adr_in)
        `BBEFC_ADR_CTRL:     wb_dat_out <= 32'(ctrl_q);
        `BBEFC_ADR_STATUS:   wb_dat_out <= 32'({open_prev_q, uv_comparator_en_out, short_q,
                                                fault_q, backlight_boost_rail_out});
        `BBEFC_ADR_IRQ_STAT: wb_dat_out <= 32'(ev_stat_q);
        `BBEFC_ADR_IRQ_MASK: wb_dat_out <= 32'(ev_mask_q);
        `BBEFC_ADR_STRINGS:  wb_dat_out <= 32'({string_sink_en_out, string_zone_two_out,
                                                string_mode_out});
        default:             wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // Boost sequencing
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q     <= bbefc_pkg::BBEFC_BOOST_OFF;
      ss_cnt_q <= 17'h0_0000;
    end else begin
      case (st_q)
        bbefc_pkg::BBEFC_BOOST_OFF: begin
          ss_cnt_q <= 17'h0_0000;
          if (boost_req) st_q <= bbefc_pkg::BBEFC_BOOST_SOFTSTART;
        end
        bbefc_pkg::BBEFC_BOOST_SOFTSTART: begin
          // Short masked until soft-start ends
          ss_cnt_q <= ss_cnt_q + 17'h0_0001;
          if (!boost_req) st_q <= bbefc_pkg::BBEFC_BOOST_OFF;
          else if (ss_cnt_q == SS_CYC - 17'h0_0001) st_q <= bbefc_pkg::BBEFC_BOOST_RAMP;
        end
        bbefc_pkg::BBEFC_BOOST_RAMP: begin
          if (!boost_req) st_q <= bbefc_pkg::BBEFC_BOOST_OFF;
          else if (sc_s) st_q <= bbefc_pkg::BBEFC_BOOST_SHORTED;
          else if (steady_s) st_q <= bbefc_pkg::BBEFC_BOOST_READY;
        end
        bbefc_pkg::BBEFC_BOOST_READY: begin
          if (!boost_req) st_q <= bbefc_pkg::BBEFC_BOOST_OFF;
          else if (sc_s) st_q <= bbefc_pkg::BBEFC_BOOST_SHORTED;
        end
        bbefc_pkg::BBEFC_BOOST_SHORTED: begin
          // Latch holds while disabled; only a fresh enable restarts
          ss_cnt_q <= 17'h0_0000;
          if (short_off_q && boost_req) st_q <= bbefc_pkg::BBEFC_BOOST_SOFTSTART;
        end
        default: st_q <= bbefc_pkg::BBEFC_BOOST_OFF;
      endcase
    end
  end

  assign short_q = (st_q == bbefc_pkg::BBEFC_BOOST_SHORTED);

  // Remembers that the request dropped while the short was latched
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      short_off_q <= 1'b0;
    end else begin
      short_off_q <= short_q & (short_off_q | ~boost_req);
    end
  end

  logic running, ready, fault_d;
  assign running = (st_q == bbefc_pkg::BBEFC_BOOST_SOFTSTART) || (st_q == bbefc_pkg::BBEFC_BOOST_RAMP)
                   || (st_q == bbefc_pkg::BBEFC_BOOST_READY);
  assign ready   = (st_q == bbefc_pkg::BBEFC_BOOST_READY);
  // Under-voltage only counts while its comparator is on
  assign fault_d = (running & ~ready) | (uv_comparator_en_out & uv_s) | (running & (ov_s | oc_s))
                   | short_q;

  // Per-string routing
  function automatic logic [1:0] str_mode(input logic on, input logic pwm);
    if (pwm) str_mode = 2'(bbefc_pkg::BBEFC_STR_PWM);
    else if (on) str_mode = 2'(bbefc_pkg::BBEFC_STR_BACKLIGHT);
    else str_mode = 2'(bbefc_pkg::BBEFC_STR_OFF);
  endfunction : str_mode

  logic [7:0] mode_d;
  logic [3:0] sink_d;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mode_d[2*i +: 2] = str_mode(main_en[i] & ~pwm_mode, pwm_mode);
    end
    if (!scene_en) mode_d[7:6] = 2'(bbefc_pkg::BBEFC_STR_OFF);
    else if (fourth_bl) mode_d[7:6] = 2'(bbefc_pkg::BBEFC_STR_BACKLIGHT);
    else mode_d[7:6] = 2'(bbefc_pkg::BBEFC_STR_SCENE);
    for (int i = 0; i < 3; i++) begin
      // Open strings are dropped; overvoltage cuts every sink except strings one to three in PWM mode
      sink_d[i] = (mode_d[2*i +: 2] != 2'(bbefc_pkg::BBEFC_STR_OFF)) & ~open_s3[i]
                  & ~(ov_s & ~pwm_mode);
    end
    sink_d[3] = scene_en & ~ov_s & ~short_q;
  end

  // Events for the status register
  always_comb begin
    ev_set = `BBEFC_EV_RST;
    ev_set[`BBEFC_EV_FAULT_SET] = fault_d & ~fault_q;
    ev_set[`BBEFC_EV_FAULT_CLR] = ~fault_d & fault_q;
    ev_set[`BBEFC_EV_SHORT]     = (st_q != bbefc_pkg::BBEFC_BOOST_SHORTED) && running && sc_s
                                  && (st_q != bbefc_pkg::BBEFC_BOOST_SOFTSTART);
    ev_set[`BBEFC_EV_OVP]       = ov_s & running;
    ev_set[`BBEFC_EV_OPEN]      = |(open_s3 & ~open_prev_q);
  end

  // Registered outputs toward the boost stage and sinks
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      backlight_boost_rail_out <= 1'b0;
      regulator_run_out        <= 1'b0;
      switch_off_out           <= 1'b1;
      uv_comparator_en_out     <= 1'b0;
      fixed_reference_out      <= 1'b0;
      clamp_22v_out            <= 1'b0;
      fault_q                  <= 1'b0;
      string_mode_out          <= 8'h00;
      string_zone_two_out      <= 4'h0;
      string_sink_en_out       <= 4'h0;
      loop_member_out          <= 3'h0;
      open_prev_q              <= 3'h0;
    end else begin
      backlight_boost_rail_out <= running;
      regulator_run_out        <= running & ~ov_s;
      switch_off_out           <= ~running | ov_s | oc_s;
      // Comparator on through start-up, then only for scene-only load
      uv_comparator_en_out     <= running & (~ready | ~any_main);
      fixed_reference_out      <= scene_en & ~any_main & ~fourth_bl;
      clamp_22v_out            <= |(open_s3 & main_en) & any_main;
      fault_q                  <= fault_d;
      string_mode_out          <= mode_d;
      // Each zone gets its own PWM timing via these zone tags
      string_zone_two_out      <= {scene_en & dual_sel, dual_sel & (main_en[2] | pwm_mode), 2'b00};
      string_sink_en_out       <= sink_d;
      loop_member_out          <= main_en & ~open_s3 & {3{any_main}};
      open_prev_q              <= open_s3;
    end
  end
  assign boost_fault_flag_out = fault_q;

  // Assertions
  fourth_needs_scene_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !scene_en |-> ##1 string_mode_out[7:6] == 2'(bbefc_pkg::BBEFC_STR_OFF))
    else $error("fourth string active without scene enable");
  boost_follows_req_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (st_q == bbefc_pkg::BBEFC_BOOST_OFF && boost_req) |-> ##2 backlight_boost_rail_out)
    else $error("boost rail not on after request");
  dual_zone_map_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (dual_sel && scene_en) |-> ##1 string_zone_two_out[3])
    else $error("string four not in zone two");
  pwm_no_boost_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (pwm_mode && !scene_en && st_q == bbefc_pkg::BBEFC_BOOST_OFF) |=> !running)
    else $error("pwm mode started boost");
  startup_fault_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(running) |-> ##1 boost_fault_flag_out && uv_comparator_en_out)
    else $error("start-up did not raise fault");
  uv_off_main_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ready && any_main) |=> !uv_comparator_en_out)
    else $error("uv comparator left on with main strings");
  ov_sinks_off_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ov_s && running) |=> !string_sink_en_out[3] && !regulator_run_out)
    else $error("overvoltage left sink or regulator on");
  oc_switch_off_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (oc_s && running) |=> switch_off_out && boost_fault_flag_out)
    else $error("overcurrent did not open switch");
  short_latched_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (short_q && boost_req && !short_off_q) |=> short_q && !backlight_boost_rail_out)
    else $error("short latch released while enabled");
  ss_mask_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (st_q == bbefc_pkg::BBEFC_BOOST_SOFTSTART) |=> st_q != bbefc_pkg::BBEFC_BOOST_SHORTED)
    else $error("short detected during soft-start");
  fixed_ref_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (scene_en && !any_main && !fourth_bl) |=> fixed_reference_out)
    else $error("fixed reference not selected");
  scene_mode_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (scene_en && !fourth_bl) |=> string_mode_out[7:6] == 2'(bbefc_pkg::BBEFC_STR_SCENE))
    else $error("fourth string not in camera scene mode");
  zone_two_string_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (dual_sel && main_en[2]) |=> string_zone_two_out[2])
    else $error("string three not in zone two");
  pwm_sink_mode_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    pwm_mode |=> string_mode_out[5:0] == {3{2'(bbefc_pkg::BBEFC_STR_PWM)}})
    else $error("strings one to three not in pwm mode");
  ready_clear_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ready && !uv_s && !ov_s && !oc_s) |=> !boost_fault_flag_out)
    else $error("fault held after boost ready");
  scene_uv_on_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ready && !any_main) |=> uv_comparator_en_out)
    else $error("uv comparator dropped for scene-only load");
  uv_fault_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (uv_comparator_en_out && uv_s) |=> boost_fault_flag_out)
    else $error("undervoltage did not raise fault");
  ov_fault_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ov_s && running) |=> boost_fault_flag_out)
    else $error("overvoltage did not raise fault");
  open_drop_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    open_s3[0] |=> !loop_member_out[0])
    else $error("open string kept in regulation loop");
  short_fault_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    short_q |=> boost_fault_flag_out)
    else $error("latched short without fault");

  boost_ready_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(ready));
  short_trip_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(short_q));
  dual_zone_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    dual_sel && any_main && scene_en && ready);
  irq_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(irq_out));
  short_restart_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    $fell(short_q) && running);
endmodule : bbefc_ctrl

// ---- bbefc_pkg.sv ----
// Types for the backlight boost enable and fault controller.
// Assumes nothing beyond the register header.
package bbefc_pkg;
  typedef enum logic [1:0] {
    BBEFC_STR_OFF,
    BBEFC_STR_BACKLIGHT,
    BBEFC_STR_PWM,
    BBEFC_STR_SCENE
  } bbefc_str_mode_t;

  typedef enum {
    BBEFC_BOOST_OFF,
    BBEFC_BOOST_SOFTSTART,
    BBEFC_BOOST_RAMP,
    BBEFC_BOOST_READY,
    BBEFC_BOOST_SHORTED
  } bbefc_boost_st_t;
endpackage : bbefc_pkg

// ---- bbefc_regs.svh ----
// Constants for the backlight boost enable and fault controller.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef BBEFC_REGS_SVH
`define BBEFC_REGS_SVH

`define BBEFC_ADR_CTRL      8'h00
`define BBEFC_ADR_STATUS    8'h04
`define BBEFC_ADR_IRQ_STAT  8'h08
`define BBEFC_ADR_IRQ_MASK  8'h0c
`define BBEFC_ADR_STRINGS   8'h10

// Control register fields
`define BBEFC_CTRL_MAIN_LSB 0
`define BBEFC_CTRL_MAIN_MSB 2
`define BBEFC_CTRL_FOURTH   3
`define BBEFC_CTRL_SCENE    4
`define BBEFC_CTRL_DUAL     5
`define BBEFC_CTRL_PWM      6
`define BBEFC_CTRL_W        7
`define BBEFC_CTRL_RST      7'h00

// Event bits (status and mask share this layout)
`define BBEFC_EV_FAULT_SET  0
`define BBEFC_EV_FAULT_CLR  1
`define BBEFC_EV_SHORT      2
`define BBEFC_EV_OVP        3
`define BBEFC_EV_OPEN       4
`define BBEFC_EV_W          5
`define BBEFC_EV_RST        5'h00

// Soft-start window: 4.0 ms at 25 MHz
`define BBEFC_SOFTSTART_US  4000
`define BBEFC_CLK_MHZ       25
`define BBEFC_SS_CYCLES     (`BBEFC_SOFTSTART_US * `BBEFC_CLK_MHZ)
`define BBEFC_SS_W          17

`endif

// ---- bbefc_sync.sv ----
// Two-flop synchroniser for a vector of detector levels.
// Assumes asynchronous inputs and one clock domain.
`timescale 1ns/1ps
module bbefc_sync #(
  parameter int W = 5
) (
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] async_in,
  output logic [W-1:0]      sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bbefc_sync

// ---- tb_backlight_boost_enable_fault_ctrl.sv ----
// Self-checking bench for the backlight boost enable and fault controller.
// Assumes the boost stage model supplies detector levels; faults other than the ramp under-voltage are commanded by the bench.
`timescale 1ns/1ps
`include "bbefc_regs.svh"
module tb_backlight_boost_enable_fault_ctrl;
  logic        core_clk_in = 1'b0;
  logic        rstn_in     = 1'b0;
  logic        wb_cyc_in   = 1'b0;
  logic        wb_stb_in   = 1'b0;
  logic        wb_we_in    = 1'b0;
  logic [7:0]  wb_adr_in   = 8'h00;
  logic [3:0]  wb_sel_in   = 4'h0;
  logic [31:0] wb_dat_in   = 32'h0;
  logic        inj_uv      = 1'b0;
  logic        inj_ov      = 1'b0;
  logic        inj_oc      = 1'b0;
  logic        inj_short   = 1'b0;
  logic [2:0]  inj_open    = 3'h0;
  logic [31:0] wb_dat_out, rdat;
  logic        wb_ack_out, irq_out, uv_detect_in, ov_detect_in, oc_detect_in, short_detect_in, steady_state_in;
  logic        backlight_boost_rail_out, regulator_run_out, switch_off_out, uv_comparator_en_out;
  logic        fixed_reference_out, clamp_22v_out, boost_fault_flag_out;
  logic [2:0]  open_string_in, loop_member_out;
  logic [7:0]  string_mode_out;
  logic [3:0]  string_zone_two_out, string_sink_en_out;
  int          error_cnt  = 0;
  int          num_checks = 0;

  bbefc_ctrl u_dut (
    .core_clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
    .wb_dat_out, .wb_ack_out, .irq_out, .uv_detect_in, .ov_detect_in, .oc_detect_in, .short_detect_in,
    .steady_state_in, .open_string_in, .backlight_boost_rail_out, .regulator_run_out, .switch_off_out,
    .uv_comparator_en_out, .fixed_reference_out, .clamp_22v_out, .boost_fault_flag_out, .string_mode_out,
    .string_zone_two_out, .string_sink_en_out, .loop_member_out
  );

  bbefc_boost_model u_stage (
    .core_clk_in, .rstn_in, .rail_in(backlight_boost_rail_out), .inj_uv_in(inj_uv), .inj_ov_in(inj_ov),
    .inj_oc_in(inj_oc), .inj_short_in(inj_short), .inj_open_in(inj_open), .uv_out(uv_detect_in),
    .ov_out(ov_detect_in), .oc_out(oc_detect_in), .short_out(short_detect_in), .steady_out(steady_state_in),
    .open_out(open_string_in)
  );

  always #20 core_clk_in = ~core_clk_in;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : wait_clk

  // Classic single cycle; read data lands in rdat
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    wb_sel_in <= sel;
    do begin
      @(posedge core_clk_in);
    end while (wb_ack_out !== 1'b1);
    rdat = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask : wb

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Expected {sink_en, zone_two, mode} for a control value
  function automatic logic [15:0] exp_str(input logic [6:0] c);
    logic [7:0] m;
    logic [3:0] z;
    logic [3:0] s;
    for (int i = 0; i < 3; i++) begin
      m[2*i +: 2] = c[6] ? 2'h2 : {1'b0, c[i]};
    end
    m[7:6] = !c[4] ? 2'h0 : ((c[5] || c[3]) ? 2'h1 : 2'h3);
    z = {c[5] && c[4], c[5] && (c[2] || c[6]), 2'b00};
    for (int i = 0; i < 4; i++) begin
      s[i] = |m[2*i +: 2];
    end
    return {s, z, m};
  endfunction : exp_str

  initial begin
    repeat (120000) @(posedge core_clk_in);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    logic [6:0] cv;
    int         n;
    repeat (12) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      wb(1'b0, 8'(a * 4), 32'h0, 4'hf);
      chk("reset value", 32'h0, rdat);
    end
    wb(1'b1, 8'h14, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h14, 32'h0, 4'hf);
    chk("unmapped read", 32'h0, rdat);
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h10, 4'he);
    wb(1'b0, `BBEFC_ADR_CTRL, 32'h0, 4'hf);
    chk("lane gated write", 32'h0, rdat);
    $display("test registers done");
    for (int c = 0; c < 128; c++) begin
      cv = c[6:0];
      if (cv[6] && |cv[2:0]) continue;
      wb(1'b1, `BBEFC_ADR_CTRL, {25'h0, cv}, 4'hf);
      wait_clk(3);
      wb(1'b0, `BBEFC_ADR_STRINGS, 32'h0, 4'hf);
      chk("string routing", {16'h0, exp_str(cv)}, rdat);
      chk("pins", {16'h0, exp_str(cv)}, {16'h0, string_sink_en_out, string_zone_two_out, string_mode_out});
      chk("boost rail", {31'h0, (|cv[2:0] && !cv[6]) || cv[4]}, backlight_boost_rail_out);
    end
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h0, 4'hf);
    wait_clk(5);
    $display("test decode done");
    wb(1'b0, `BBEFC_ADR_IRQ_STAT, 32'h0, 4'hf);
    chk("irq status", 32'h3, rdat);
    chk("irq masked", 32'h0, irq_out);
    wb(1'b1, `BBEFC_ADR_IRQ_MASK, 32'h1, 4'hf);
    wait_clk(3);
    chk("irq raised", 32'h1, irq_out);
    wb(1'b1, `BBEFC_ADR_IRQ_STAT, 32'h1f, 4'hf);
    wait_clk(3);
    wb(1'b0, `BBEFC_ADR_IRQ_STAT, 32'h0, 4'hf);
    chk("irq status cleared", 32'h0, rdat);
    chk("irq dropped", 32'h0, irq_out);
    $display("test interrupt done");
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h10, 4'hf);
    wait_clk(10);
    chk("fault at start", 32'h1, boost_fault_flag_out);
    chk("uv comparator at start", 32'h1, uv_comparator_en_out);
    n = 0;
    while (boost_fault_flag_out !== 1'b0) begin
      @(posedge core_clk_in);
      n++;
    end
    chk("ramp span", 32'h1, {31'h0, n >= 100030 && n < 110000});
    wait_clk(2);
    chk("uv comparator scene only", 32'h1, uv_comparator_en_out);
    chk("fixed reference", 32'h1, fixed_reference_out);
    wb(1'b0, `BBEFC_ADR_STATUS, 32'h0, 4'hf);
    chk("status ready", 32'h9, rdat);
    inj_uv <= 1'b1;
    wait_clk(5);
    chk("fault on uv", 32'h1, boost_fault_flag_out);
    inj_uv <= 1'b0;
    wait_clk(5);
    chk("fault after uv", 32'h0, boost_fault_flag_out);
    inj_ov <= 1'b1;
    wait_clk(5);
    chk("regulator on ov", 32'h0, regulator_run_out);
    chk("fault on ov", 32'h1, boost_fault_flag_out);
    chk("sinks on ov", 32'h0, string_sink_en_out);
    inj_ov <= 1'b0;
    wait_clk(5);
    chk("regulator after ov", 32'h1, regulator_run_out);
    chk("fault after ov", 32'h0, boost_fault_flag_out);
    chk("sinks after ov", 32'h8, string_sink_en_out);
    inj_oc <= 1'b1;
    wait_clk(5);
    chk("switch on oc", 32'h1, switch_off_out);
    chk("fault on oc", 32'h1, boost_fault_flag_out);
    inj_oc <= 1'b0;
    wait_clk(5);
    chk("switch after oc", 32'h0, switch_off_out);
    chk("fault after oc", 32'h0, boost_fault_flag_out);
    $display("test live faults done");
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h17, 4'hf);
    wait_clk(5);
    chk("uv comparator with main", 32'h0, uv_comparator_en_out);
    chk("adaptive reference", 32'h0, fixed_reference_out);
    inj_open <= 3'b010;
    wait_clk(5);
    chk("loop members", 32'h5, loop_member_out);
    chk("output clamp", 32'h1, clamp_22v_out);
    inj_open <= 3'b000;
    inj_short <= 1'b1;
    wait_clk(5);
    chk("rail on short", 32'h0, backlight_boost_rail_out);
    inj_short <= 1'b0;
    wait_clk(20);
    chk("no restart", 32'h0, backlight_boost_rail_out);
    wb(1'b0, `BBEFC_ADR_STATUS, 32'h0, 4'hf);
    chk("short latched", 32'h6, rdat & 32'h7);
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h0, 4'hf);
    wb(1'b0, `BBEFC_ADR_STATUS, 32'h0, 4'hf);
    chk("short held while off", 32'h6, rdat & 32'h7);
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h10, 4'hf);
    wait_clk(5);
    wb(1'b0, `BBEFC_ADR_STATUS, 32'h0, 4'hf);
    chk("short after re-enable", 32'h3, rdat & 32'h7);
    inj_short <= 1'b1;
    wait_clk(200);
    chk("short masked in soft-start", 32'h1, backlight_boost_rail_out);
    inj_short <= 1'b0;
    wb(1'b0, `BBEFC_ADR_IRQ_STAT, 32'h0, 4'hf);
    chk("event bits", 32'h1f, rdat);
    chk("irq on events", 32'h1, irq_out);
    wb(1'b1, `BBEFC_ADR_CTRL, 32'h0, 4'hf);
    $display("test short circuit done");
    report_and_stop();
  end
endmodule : tb_backlight_boost_enable_fault_ctrl
